// [system_warning_flag_logger.sv]
// warning summary word, diagnostic records and histories behind AHB-Lite
// assumes all inputs synchronous to clk; single word transfers only
//
// Summary of operation
// - one summary warning word of live warnings
// - bit 0 flags invalid clock data
// - bit 3 set on aborted restore
// - bit 3 cleared when initialization completes
// - emergency stop sets bit 3 likewise
// - bit 4 flags repeated task request
// - bit 5 follows low battery voltage
// - bit 6 shows any warning bitmap bit
// - bit 8 set on failed parameter check
// - bit 8 cleared while communication disabled
// - report lowest failing I/O slot
// - eight nonzero external fatal codes
// - warning positions listed in occurrence order
// - per-task collision bitmap bits
// - per-task collision counters
// - latch first battery drop time, clear on recovery
// - count run-mode power failures, 16 bits
// - sixteen power failure timestamps
// - sixteen error records, time plus code
// - sixteen mode change records
// - timestamps kept only with clock unit
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none

module hist_ring #(
	parameter int W = 64,
	parameter int DEPTH = 16
) (
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	input  wire logic                     clkEn,
	input  wire logic                     push,
	input  wire logic [W-1:0]             wrData,
	input  wire logic [$clog2(DEPTH)-1:0] rdIdx,
	output logic      [W-1:0]             rdData,
	output logic      [$clog2(DEPTH)-1:0] wrPtr
);
	logic [W-1:0] memQ [DEPTH];
	logic [$clog2(DEPTH)-1:0] ptrQ;
	assign rdData = memQ[rdIdx];
	assign wrPtr = ptrQ;
	// pointer wraps, so the oldest slot is the one overwritten
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ptrQ <= '0;
			for (int i = 0; i < DEPTH; i++)
				memQ[i] <= '0;
		end
		else if (clkEn && push)
		begin
			memQ[ptrQ] <= wrData;
			ptrQ <= ptrQ + 1'b1;
		end
	end
endmodule

module system_warning_flag_logger (
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	input  wire logic                     clkEn,
	input  wire warn_log_pkg::ahb_req_t   ahbReq,
	output var  warn_log_pkg::ahb_rsp_t   ahbRsp,
	input  wire warn_log_pkg::sys_evt_t   sysEvt,
	input  wire logic                     rtcPresent,
	input  wire logic                     rtcInvalid,
	input  wire logic                     dataBackupFault,
	input  wire logic                     batteryLow,
	input  wire logic                     commEnable,
	input  wire logic                     commParamFail,
	input  wire logic [15:0]              ioSlotFail,
	input  wire logic [7:0]               taskReq,
	input  wire logic [7:0]               taskPending,
	input  wire logic                     extFatalWe,
	input  wire logic [2:0]               extFatalIdx,
	input  wire logic [15:0]              extFatalCode,
	input  wire logic [63:0]              timeNow
);
	import warn_log_pkg::*;

	function automatic logic [3:0] lowSlot(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = N_SLOT - 1; i >= 0; i--)
			if (v[i])
				r = 4'(i);
		return r;
	endfunction

	function automatic logic [6:0] lowBit(input logic [127:0] v);
		logic [6:0] r;
		r = 7'h00;
		for (int i = WMAP_BITS - 1; i >= 0; i--)
			if (v[i])
				r = 7'(i);
		return r;
	endfunction

	logic        abnQ;
	logic        commErrQ;
	logic [3:0]  slotQ;
	logic [15:0] pfCntQ;
	logic [7:0]  tcMapQ;
	logic [15:0] tcCntQ [N_TASK];
	logic [15:0] fatalQ [N_FATAL];
	logic [6:0]  wlistQ [N_WLIST];
	logic [3:0]  wlCntQ;
	logic [127:0] wmapQ;
	logic [127:0] pendQ;
	logic [63:0] battTsQ;
	logic        battValidQ;
	logic        wrPendQ;
	logic [AW-1:0] wrAddrQ;
	logic [31:0] hrdataQ;

	// bus decode
	wire [AW-1:0] a = ahbReq.haddr;
	wire accept = clkEn && ahbReq.hready && ahbReq.hsel && ahbReq.htrans == HTRANS_NONSEQ;
	wire doWrite = clkEn && wrPendQ;
	wire wrWmap = doWrite && wrAddrQ[9:4] == BASE_WMAP[9:4];
	wire wrTcMap = doWrite && wrAddrQ == OFF_TCMAP;
	wire [1:0] wIdx = wrAddrQ[3:2];
	wire [2:0] rIdx = a[4:2];
	wire [3:0] hIdx = a[7:4];
	wire [3:0] pIdx = a[6:3];

	// summary word: only documented positions carry a flag
	wire [15:0] warnWord = {7'h00, commErrQ, 1'b0, |wmapQ, batteryLow, |tcMapQ,
		abnQ, 1'b0, dataBackupFault, rtcInvalid};

	// event terms
	wire abnSet = sysEvt.restoreAbort || sysEvt.estopStop;
	wire commSet = commEnable && commParamFail;
	wire [7:0] collide = taskReq & taskPending;
	wire pfCountUp = sysEvt.pwrFail && sysEvt.runMode && pfCntQ != CNT_MAX;
	wire battLatch = batteryLow && rtcPresent && !battValidQ;

	// warning bitmap, with position zero forced clear
	logic [127:0] wmapD;
	always_comb
	begin
		wmapD = wmapQ;
		if (wrWmap)
			wmapD[32*wIdx +: 32] = ahbReq.hwdata;
		wmapD[0] = 1'b0;
	end
	wire [127:0] newBits = wmapD & ~wmapQ;
	wire [6:0] pendLow = lowBit(pendQ);
	wire pendAny = |pendQ;
	wire [127:0] pendClr = pendAny ? (128'h1 << pendLow) : 128'h0;

	// histories
	wire [63:0] pfRd;
	wire [79:0] errRd;
	wire [79:0] modeRd;
	wire [3:0] pfPtr;
	wire [3:0] errPtr;
	wire [3:0] modePtr;
	hist_ring #(.W(64), .DEPTH(N_HIST)) pfHist (
		.clk    (clk),
		.arst_n (arst_n),
		.clkEn  (clkEn),
		.push   (sysEvt.pwrFail && rtcPresent),
		.wrData (timeNow),
		.rdIdx  (pIdx),
		.rdData (pfRd),
		.wrPtr  (pfPtr)
	);
	hist_ring #(.W(80), .DEPTH(N_HIST)) errHist (
		.clk    (clk),
		.arst_n (arst_n),
		.clkEn  (clkEn),
		.push   (sysEvt.errEvt && rtcPresent),
		.wrData ({timeNow, sysEvt.errCode}),
		.rdIdx  (hIdx),
		.rdData (errRd),
		.wrPtr  (errPtr)
	);
	hist_ring #(.W(80), .DEPTH(N_HIST)) modeHist (
		.clk    (clk),
		.arst_n (arst_n),
		.clkEn  (clkEn),
		.push   (sysEvt.modeEvt && rtcPresent),
		.wrData ({timeNow, sysEvt.restartMode, sysEvt.newMode}),
		.rdIdx  (hIdx),
		.rdData (modeRd),
		.wrPtr  (modePtr)
	);

	// read selection
	wire selFatal = a[9:5] == BASE_FATAL[9:5];
	wire selWlist = a[9:5] == BASE_WLIST[9:5];
	wire selWmap = a[9:4] == BASE_WMAP[9:4];
	wire selTcCnt = a[9:5] == BASE_TCCNT[9:5];
	wire selPfh = a[9:7] == BASE_PFH[9:7];
	wire selErrh = a[9:8] == BASE_ERRH[9:8];
	wire selModeh = a[9:8] == BASE_MODEH[9:8];
	wire [79:0] hRec = selErrh ? errRd : modeRd;
	wire [31:0] hWord = a[3:2] == 2'd0 ? hRec[47:16] :
		a[3:2] == 2'd1 ? {16'h0000, hRec[79:64]} :
		a[3:2] == 2'd2 ? {16'h0000, hRec[15:0]} : RD_RST;
	wire [31:0] rdMux =
		a == OFF_WARN ? {16'h0000, warnWord} :
		a == OFF_SLOT ? {28'h0, slotQ} :
		a == OFF_PFCNT ? {16'h0000, pfCntQ} :
		a == OFF_TCMAP ? {24'h0, tcMapQ} :
		a == OFF_PTRS ? {20'h0, modePtr, errPtr, pfPtr} :
		a == OFF_BATLO ? battTsQ[31:0] :
		a == OFF_BATHI ? battTsQ[63:32] :
		selFatal ? {16'h0000, fatalQ[rIdx]} :
		selWlist ? {25'h0, wlistQ[rIdx]} :
		selWmap ? wmapQ[32*a[3:2] +: 32] :
		selTcCnt ? {16'h0000, tcCntQ[rIdx]} :
		selPfh ? (a[2] ? pfRd[63:32] : pfRd[31:0]) :
		(selErrh || selModeh) ? hWord : RD_RST;

	// no wait states; a frozen clock enable stalls the master instead
	assign ahbRsp.hrdata = hrdataQ;
	assign ahbRsp.hreadyout = clkEn;
	assign ahbRsp.hresp = HRESP_OKAY;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wrPendQ <= 1'b0;
			wrAddrQ <= '0;
			hrdataQ <= RD_RST;
		end
		else if (clkEn)
		begin
			wrPendQ <= accept && ahbReq.hwrite;
			wrAddrQ <= a;
			if (accept && !ahbReq.hwrite)
				hrdataQ <= rdMux;
		end
	end

	// summary flags; set wins over clear in the same cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			abnQ <= 1'b0;
			commErrQ <= 1'b0;
			slotQ <= 4'h0;
		end
		else if (clkEn)
		begin
			abnQ <= abnSet || (abnQ && !sysEvt.initDone);
			commErrQ <= commSet || (commErrQ && commEnable);
			slotQ <= lowSlot(ioSlotFail);
		end
	end

	// task collisions; software clears map bits by writing ones
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tcMapQ <= 8'h00;
			for (int i = 0; i < N_TASK; i++)
				tcCntQ[i] <= CNT_RST;
		end
		else if (clkEn)
		begin
			tcMapQ <= collide | (tcMapQ & ~(wrTcMap ? ahbReq.hwdata[7:0] : 8'h00));
			for (int i = 0; i < N_TASK; i++)
				if (collide[i])
					tcCntQ[i] <= tcCntQ[i] + 1'b1;
		end
	end

	// external fatal codes; a zero code is not a code and is dropped
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < N_FATAL; i++)
				fatalQ[i] <= CNT_RST;
		end
		else if (clkEn && extFatalWe && extFatalCode != CNT_RST)
			fatalQ[extFatalIdx] <= extFatalCode;
	end

	// bitmap and ordered list; one new position is listed per cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wmapQ <= '0;
			pendQ <= '0;
			wlCntQ <= 4'h0;
			for (int i = 0; i < N_WLIST; i++)
				wlistQ[i] <= 7'h00;
		end
		else if (clkEn)
		begin
			wmapQ <= wmapD;
			pendQ <= (pendQ & ~pendClr) | newBits;
			if (wmapD == '0)
				wlCntQ <= 4'h0;
			else if (pendAny && wlCntQ < 4'(N_WLIST))
			begin
				wlistQ[wlCntQ[2:0]] <= pendLow;
				wlCntQ <= wlCntQ + 1'b1;
			end
		end
	end

	// power failure count saturates rather than wrapping to zero
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pfCntQ <= CNT_RST;
			battTsQ <= TIME_RST;
			battValidQ <= 1'b0;
		end
		else if (clkEn)
		begin
			if (pfCountUp)
				pfCntQ <= pfCntQ + 1'b1;
			if (!batteryLow)
			begin
				battTsQ <= TIME_RST;
				battValidQ <= 1'b0;
			end
			else if (battLatch)
			begin
				battTsQ <= timeNow;
				battValidQ <= 1'b1;
			end
		end
	end

	sequence abortSeq;
		clkEn && abnSet;
	endsequence
	sequence initSeq;
		clkEn && sysEvt.initDone && !abnSet;
	endsequence
	sequence dropSeq;
		clkEn && battLatch;
	endsequence

	abnSet_a: assert property (@(posedge clk) disable iff (!arst_n) abortSeq |=> abnQ && warnWord[BIT_ABN])
		else $error("abnormal shutdown not set");
	abnClr_a: assert property (@(posedge clk) disable iff (!arst_n) initSeq |=> !warnWord[BIT_ABN])
		else $error("abnormal shutdown not cleared");
	commClr_a: assert property (@(posedge clk) disable iff (!arst_n) clkEn && !commEnable |=> !warnWord[BIT_COMM])
		else $error("comm error held while disabled");
	commSet_a: assert property (@(posedge clk) disable iff (!arst_n) clkEn && commSet |=> warnWord[BIT_COMM])
		else $error("comm error not set");
	unusedZero_a: assert property (@(posedge clk) disable iff (!arst_n) warnWord[15:9] == 7'h00 && !warnWord[7] && !warnWord[2])
		else $error("unused warning bit set");
	taskSet_a: assert property (@(posedge clk) disable iff (!arst_n) clkEn && |collide |=> warnWord[BIT_TASK] && (tcMapQ & $past(collide)) == $past(collide))
		else $error("collision not recorded");
	pfCount_a: assert property (@(posedge clk) disable iff (!arst_n) clkEn && pfCountUp |=> pfCntQ == $past(pfCntQ) + 16'h0001)
		else $error("power failure count wrong");
	battHold_a: assert property (@(posedge clk) disable iff (!arst_n) dropSeq ##1 (batteryLow && clkEn)[*2] |=> battTsQ == $past(timeNow, 3))
		else $error("battery drop time not held");
	battClr_a: assert property (@(posedge clk) disable iff (!arst_n) clkEn && !batteryLow |=> battTsQ == TIME_RST && !battValidQ)
		else $error("battery drop time not cleared");
	slotZero_a: assert property (@(posedge clk) disable iff (!arst_n) clkEn && ioSlotFail[0] |=> slotQ == 4'h0)
		else $error("lowest slot wrong");
	mapZero_a: assert property (@(posedge clk) disable iff (!arst_n) !wmapQ[0])
		else $error("bitmap position zero set");
endmodule

`default_nettype wire

// [tb_top.sv]
// self-checking bench for the warning flag logger
// assumes the logger is the only slave on its AHB-Lite bus
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import warn_log_pkg::*;
	logic        clk;
	logic        arstN;
	logic        clkEn;
	ahb_req_t    m;
	ahb_req_t    busReq;
	ahb_rsp_t    rsp;
	sys_evt_t    ev;
	sys_evt_t    e;
	logic        rtcPresent;
	logic        rtcInvalid;
	logic        bckFault;
	logic        batteryLow;
	logic        commEnable;
	logic        commParamFail;
	logic [15:0] ioSlotFail;
	logic [7:0]  taskReq;
	logic [7:0]  taskPending;
	logic        fatalWe;
	logic [2:0]  fatalIdx;
	logic [15:0] fatalCode;
	logic [63:0] timeNow = 64'h0;
	logic [63:0] tPulse;
	logic [31:0] d;
	int          nErrors;
	int          checks;
	int          cyc = 0;

	system_warning_flag_logger uut (
		.clk            (clk),
		.arst_n         (arstN),
		.clkEn          (clkEn),
		.ahbReq         (busReq),
		.ahbRsp         (rsp),
		.sysEvt         (ev),
		.rtcPresent     (rtcPresent),
		.rtcInvalid     (rtcInvalid),
		.dataBackupFault(bckFault),
		.batteryLow     (batteryLow),
		.commEnable     (commEnable),
		.commParamFail  (commParamFail),
		.ioSlotFail     (ioSlotFail),
		.taskReq        (taskReq),
		.taskPending    (taskPending),
		.extFatalWe     (fatalWe),
		.extFatalIdx    (fatalIdx),
		.extFatalCode   (fatalCode),
		.timeNow        (timeNow)
	);

	// one slave, so its ready is the bus ready
	always_comb
	begin
		busReq = m;
		busReq.hready = rsp.hreadyout;
	end

	always #12.5 clk = ~clk;

	always @(posedge clk)
	begin
		timeNow <= timeNow + 64'h1;
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			nErrors++;
			test_done();
		end
	end

	task automatic test_done;
		if (nErrors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			nErrors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// no cycle count assumed: waits on ready, the timeout cuts a hang
	task automatic xfer(input logic [9:0] a, input logic wr, input logic [31:0] wd);
		m.hsel <= 1'b1;
		m.haddr <= a;
		m.htrans <= HTRANS_NONSEQ;
		m.hwrite <= wr;
		m.hsize <= 3'h2;
		do @(posedge clk); while (rsp.hreadyout !== 1'b1);
		m.htrans <= 2'h0;
		m.hsel <= 1'b0;
		m.hwdata <= wd;
		do @(posedge clk); while (rsp.hreadyout !== 1'b1);
		d = rsp.hrdata;
	endtask

	task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		chk(d, exp);
		chk({31'h0, rsp.hresp}, {31'h0, HRESP_OKAY});
	endtask

	// pulse stays one cycle; tPulse is the time the logger samples
	task automatic evPulse(input sys_evt_t p);
		ev <= ev | p;
		tPulse = timeNow + 64'h1;
		tick(1);
		ev <= ev & ~p;
		tick(1);
	endtask

	task automatic summaryTest;
		rdc(OFF_WARN, 32'h0);
		rtcInvalid <= 1'b1;
		bckFault <= 1'b1;
		commEnable <= 1'b1;
		commParamFail <= 1'b1;
		tick(2);
		rdc(OFF_WARN, 32'h103);
		rtcInvalid <= 1'b0;
		commEnable <= 1'b0;
		tick(2);
		rdc(OFF_WARN, 32'h2);
		bckFault <= 1'b0;
		commParamFail <= 1'b0;
		tick(2);
	endtask

	task automatic abnTest;
		e = '0;
		e.restoreAbort = 1'b1;
		evPulse(e);
		rdc(OFF_WARN, 32'h8);
		e = '0;
		e.initDone = 1'b1;
		evPulse(e);
		rdc(OFF_WARN, 32'h0);
		e = '0;
		e.estopStop = 1'b1;
		evPulse(e);
		rdc(OFF_WARN, 32'h8);
		e = '0;
		e.initDone = 1'b1;
		evPulse(e);
		rdc(OFF_WARN, 32'h0);
	endtask

	task automatic slotTest;
		ioSlotFail <= 16'h00a0;
		tick(2);
		rdc(OFF_SLOT, 32'h5);
		ioSlotFail <= 16'h8000;
		tick(2);
		rdc(OFF_SLOT, 32'hf);
		ioSlotFail <= 16'h0000;
	endtask

	// task 0 is requested while idle, so only task 2 collides
	task automatic taskTest;
		taskPending <= 8'h04;
		taskReq <= 8'h05;
		tick(1);
		taskReq <= 8'h00;
		tick(1);
		taskReq <= 8'h04;
		tick(1);
		taskReq <= 8'h00;
		tick(2);
		rdc(OFF_TCMAP, 32'h4);
		rdc(BASE_TCCNT + 10'h008, 32'h2);
		rdc(BASE_TCCNT, 32'h0);
		rdc(OFF_WARN, 32'h10);
		taskPending <= 8'h00;
		xfer(OFF_TCMAP, 1'b1, 32'h4);
		rdc(OFF_TCMAP, 32'h0);
	endtask

	task automatic wmapTest;
		xfer(BASE_WMAP, 1'b1, 32'h21);
		xfer(BASE_WMAP + 10'h004, 1'b1, 32'h1);
		tick(4);
		rdc(BASE_WMAP, 32'h20);
		rdc(BASE_WLIST, 32'h5);
		rdc(BASE_WLIST + 10'h004, 32'h20);
		rdc(OFF_WARN, 32'h40);
		xfer(10'h070, 1'b1, 32'hff);
		rdc(10'h070, 32'h0);
		xfer(BASE_WMAP, 1'b1, 32'h0);
		xfer(BASE_WMAP + 10'h004, 1'b1, 32'h0);
		tick(2);
		rdc(OFF_WARN, 32'h0);
	endtask

	// a zero code in the next cycle must not overwrite the entry
	task automatic fatalTest;
		fatalIdx <= 3'h3;
		fatalCode <= 16'h0042;
		fatalWe <= 1'b1;
		tick(1);
		fatalCode <= 16'h0000;
		tick(1);
		fatalWe <= 1'b0;
		tick(1);
		rdc(BASE_FATAL + 10'h00c, 32'h42);
	endtask

	task automatic batTest;
		batteryLow <= 1'b1;
		tick(2);
		rdc(OFF_WARN, 32'h20);
		rdc(OFF_BATLO, 32'h0);
		rtcPresent <= 1'b1;
		tPulse = timeNow + 64'h1;
		tick(3);
		rdc(OFF_BATLO, tPulse[31:0]);
		rdc(OFF_BATHI, tPulse[63:32]);
		batteryLow <= 1'b0;
		tick(2);
		rdc(OFF_BATLO, 32'h0);
	endtask

	task automatic histTest;
		rtcPresent <= 1'b0;
		e = '0;
		e.errEvt = 1'b1;
		e.errCode = 16'h00a5;
		evPulse(e);
		rdc(OFF_PTRS, 32'h0);
		rtcPresent <= 1'b1;
		evPulse(e);
		rdc(BASE_ERRH + 10'h008, 32'ha5);
		e = '0;
		e.modeEvt = 1'b1;
		e.newMode = 8'h03;
		e.restartMode = 8'h02;
		evPulse(e);
		rdc(BASE_MODEH + 10'h008, 32'h0203);
		e = '0;
		e.pwrFail = 1'b1;
		evPulse(e);
		// own edge, so the pulse update cannot swallow the mode bit
		ev.runMode <= 1'b1;
		tick(1);
		repeat (16) evPulse(e);
		rdc(OFF_PFCNT, 32'h10);
		rdc(OFF_PTRS, 32'h111);
		rdc(BASE_PFH, tPulse[31:0]);
	endtask

	// events while the enable is low must leave no trace; the read waits
	task automatic stallTest;
		clkEn <= 1'b0;
		e = '0;
		e.restoreAbort = 1'b1;
		e.pwrFail = 1'b1;
		evPulse(e);
		fork
			rdc(OFF_WARN, 32'h0);
			begin
				tick(2);
				clkEn <= 1'b1;
			end
		join
		rdc(OFF_PFCNT, 32'h10);
		rdc(OFF_PTRS, 32'h111);
	endtask

	initial
	begin
		clk = 1'b0;
		arstN = 1'b0;
		clkEn = 1'b1;
		m = '0;
		ev = '0;
		rtcPresent = 1'b0;
		rtcInvalid = 1'b0;
		bckFault = 1'b0;
		batteryLow = 1'b0;
		commEnable = 1'b0;
		commParamFail = 1'b0;
		ioSlotFail = 16'h0000;
		taskReq = 8'h00;
		taskPending = 8'h00;
		fatalWe = 1'b0;
		fatalIdx = 3'h0;
		fatalCode = 16'h0000;
		nErrors = 0;
		checks = 0;
		tick(6);
		arstN <= 1'b1;
		tick(1);
		summaryTest();
		abnTest();
		slotTest();
		taskTest();
		wmapTest();
		fatalTest();
		batTest();
		histTest();
		stallTest();
		test_done();
	end
endmodule
`default_nettype wire

// [warn_log_pkg.sv]
// constants, field positions and carriers for the warning flag logger
// assumes a single 40 MHz clock and an AHB-Lite master with one slave
`default_nettype none
package warn_log_pkg;
	localparam int AW = 10;
	localparam int CLK_MHZ = 40;
	localparam logic [9:0] OFF_WARN = 10'h000;
	localparam logic [9:0] OFF_SLOT = 10'h004;
	localparam logic [9:0] OFF_PFCNT = 10'h008;
	localparam logic [9:0] OFF_TCMAP = 10'h00c;
	localparam logic [9:0] OFF_PTRS = 10'h010;
	localparam logic [9:0] OFF_BATLO = 10'h014;
	localparam logic [9:0] OFF_BATHI = 10'h018;
	localparam logic [9:0] BASE_FATAL = 10'h020;
	localparam logic [9:0] BASE_WLIST = 10'h040;
	localparam logic [9:0] BASE_WMAP = 10'h060;
	localparam logic [9:0] BASE_TCCNT = 10'h080;
	localparam logic [9:0] BASE_PFH = 10'h100;
	localparam logic [9:0] BASE_ERRH = 10'h200;
	localparam logic [9:0] BASE_MODEH = 10'h300;
	localparam int BIT_RTC = 0;
	localparam int BIT_BCK = 1;
	localparam int BIT_ABN = 3;
	localparam int BIT_TASK = 4;
	localparam int BIT_BAT = 5;
	localparam int BIT_EXT = 6;
	localparam int BIT_COMM = 8;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [63:0] TIME_RST = 64'h0;
	localparam logic [31:0] RD_RST = 32'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic HRESP_OKAY = 1'b0;
	localparam int N_TASK = 8;
	localparam int N_FATAL = 8;
	localparam int N_WLIST = 8;
	localparam int N_SLOT = 16;
	localparam int N_HIST = 16;
	localparam int WMAP_BITS = 128;
	typedef struct packed {
		logic           hsel;
		logic [AW-1:0]  haddr;
		logic [1:0]     htrans;
		logic           hwrite;
		logic [2:0]     hsize;
		logic [31:0]    hwdata;
		logic           hready;
	} ahb_req_t;
	typedef struct packed {
		logic [31:0]    hrdata;
		logic           hreadyout;
		logic           hresp;
	} ahb_rsp_t;
	typedef struct packed {
		logic           restoreAbort;
		logic           estopStop;
		logic           initDone;
		logic           pwrFail;
		logic           runMode;
		logic           errEvt;
		logic [15:0]    errCode;
		logic           modeEvt;
		logic [7:0]     newMode;
		logic [7:0]     restartMode;
	} sys_evt_t;
endpackage
`default_nettype wire
